// >>> logic/scsci_pkg.sv
package scsci_pkg;

  // ----------------------------------------------------------------
  // clocks and conversion timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_HZ = 125_000_000;
  localparam int INT_CONV_FREQ_HZ = 20_000_000;
  localparam int EXT_CONV_MAX_HZ = 20_000_000;
  // half period of the internal conversion clock, rounded down
  localparam int INT_HALF_CYC = CLK_FREQ_HZ / (2 * INT_CONV_FREQ_HZ);
  localparam logic [3:0] INT_HALF_LAST = 4'(INT_HALF_CYC - 1);
  // 18.5 conversion clock cycles counted as clock edges
  localparam int CONV_CYCLES_X2 = 37;
  localparam logic [5:0] CONV_EDGE_LAST = 6'(CONV_CYCLES_X2 - 1);

  // ----------------------------------------------------------------
  // control word fields
  // ----------------------------------------------------------------
  localparam int CW_DAC_LSB = 0;
  localparam int CW_CONVERSION_CLOCK_SELECT = 11;
  localparam int CW_PD_LSB = 13;
  localparam int CW_FULL_UPD = 16;
  localparam int CW_REF_RANGE = 18;
  localparam int CW_BUSY_POL = 20;
  localparam int CW_SEQ = 23;
  localparam int CW_UPPER_LSB = 24;
  localparam logic [31:0] CW_RESET = 32'h0000_0000;
  // bits that may override pins in pin-configured mode
  localparam logic [31:0] CW_HW_MASK = 32'h007c_e3ff;

  // ----------------------------------------------------------------
  // data format and serial framing
  // ----------------------------------------------------------------
  localparam int RESOLUTION = 16;
  localparam logic [15:0] RES_MASK = 16'hffff >> (16 - RESOLUTION);
  localparam int FRAME_BITS = 96;
  localparam logic [5:0] CFG_LAST_BIT = 6'h1f;
  localparam logic [3:0] PAR_LAST_WORD = 4'h5;
  localparam logic [3:0] PAR_LAST_BYTE = 4'hb;

  // six results: 0 a-first, 1 a-second, 2 b-first ... 5 c-second
  typedef logic [5:0][15:0] scsci_six_t;

  typedef struct packed {
    logic sel_a;
    logic sel_b;
    logic sel_c;
  } scsci_sel_t;

  typedef struct packed {
    logic [2:0] start;
    logic ext_clk;
    logic cfg_sw;
    logic if_serial;
    logic byte_mode;
    logic high_first;
    logic cs_n;
    logic rd_n;
    logic fs;
  } scsci_pins_t;

  localparam scsci_pins_t PINS_RESET = 11'h007;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_CONV = 2'b10
  } scsci_conv_t;

endpackage

// >>> logic/scsci_top.sv
`timescale 1ns/100ps
// Function
// - internal conversion clock unless select bit set
// - conversion lasts 18.5 conversion clock cycles
// - start edge holds pair, converts next edge
// - software mode: pair A start drives all, except in sequential mode
// - start falling mid-conversion powers pair down
// - starts during any conversion are ignored, except for idle pairs in sequential mode
// - busy rises on start, falls when loaded
// - busy polarity follows control bit
// - reference range bit selects three volt
// - ten-bit reference code driven from control
// - pin mode: only override bits are used
// - software mode: control word only, serial update
// - interface select low: parallel, width select
// - byte mode uses upper lanes, order select
// - frame sync starts transfer, msb first
// - serial config input latched on falling edges
// - three outputs: first then second channel
// - two outputs: a,b carry pairs plus c
// - one output carries all six channels
// - results in two's complement
// - 14-bit results zero upper two bits
// - 12-bit results zero upper four bits
// - reset aborts, restores defaults, samples
module scsci_top (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic sclk_i,
  input wire logic external_conversion_clock_i,
  input wire logic [2:0] pair_conversion_start_i,
  input wire logic pin_or_register_config_select_i,
  input wire logic interface_select_i,
  input wire logic width_select_i,
  input wire logic byte_order_select_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic frame_sync_i,
  input wire logic serial_config_input_i,
  input wire scsci_pkg::scsci_sel_t serial_output_enable_i,
  input wire logic [31:0] control_word_i,
  input wire scsci_pkg::scsci_six_t sample_data_i,
  output logic busy_int_o,
  output logic ref_range_o,
  output logic [9:0] ref_dac_code_o,
  output logic [2:0] pair_power_down_o,
  output logic [15:0] parallel_lanes_o,
  output logic parallel_lanes_oe_o,
  output logic serial_output_a_o,
  output logic serial_output_b_o,
  output logic serial_output_c_o
);
  import scsci_pkg::*;

  // ----------------------------------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_n_reg;
  scsci_pins_t pins_meta_reg;
  scsci_pins_t pins_reg;
  scsci_pins_t pins_q_reg;
  scsci_pins_t pins_in;

  assign pins_in = {pair_conversion_start_i, external_conversion_clock_i,
    pin_or_register_config_select_i, interface_select_i, width_select_i,
    byte_order_select_i, cs_n_i, rd_n_i, frame_sync_i};

  // reset released through two flops
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // pins cross in via two flops, third stage for edges
  always_ff @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      pins_meta_reg <= PINS_RESET;
      pins_reg <= PINS_RESET;
      pins_q_reg <= PINS_RESET;
    end else begin
      pins_meta_reg <= pins_in;
      pins_reg <= pins_meta_reg;
      pins_q_reg <= pins_reg;
    end
  end

  // ----------------------------------------------------------------
  // effective configuration
  // ----------------------------------------------------------------
  logic [31:0] ser_cw_reg;
  logic [31:0] ser_cw_next;
  logic [31:0] cw_eff;
  logic [31:0] cw_reg;
  logic [31:0] ser_rx_word;
  logic ser_rx_full;
  wire fs_rise = pins_reg.fs & ~pins_q_reg.fs;
  wire ser_sw = pins_reg.cfg_sw & pins_reg.if_serial;

  // control word only in software mode; pin mode masks to overrides
  assign cw_eff = pins_reg.cfg_sw
    ? (pins_reg.if_serial ? ser_cw_reg : control_word_i)
    : (control_word_i & CW_HW_MASK);

  // serial update taken once the frame has ended
  assign ser_cw_next = !(fs_rise && ser_sw && ser_rx_full) ? ser_cw_reg
    : ser_rx_word[CW_FULL_UPD] ? ser_rx_word
    : {ser_rx_word[31:CW_UPPER_LSB], ser_cw_reg[CW_UPPER_LSB-1:0]};

  // configuration registers, defaults on reset
  always_ff @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ser_cw_reg <= CW_RESET;
      cw_reg <= CW_RESET;
    end else begin
      ser_cw_reg <= ser_cw_next;
      cw_reg <= cw_eff;
    end
  end

  assign ref_range_o = cw_reg[CW_REF_RANGE];
  assign ref_dac_code_o = cw_reg[CW_DAC_LSB +: 10];

  // ----------------------------------------------------------------
  // conversion clock
  // ----------------------------------------------------------------
  logic [3:0] int_cnt_reg;
  logic int_clk_reg;
  wire int_wrap = (int_cnt_reg == INT_HALF_LAST);
  wire use_ext = pins_reg.cfg_sw & cw_reg[CW_CONVERSION_CLOCK_SELECT];
  wire ext_edge = pins_reg.ext_clk ^ pins_q_reg.ext_clk;
  // every edge of the selected clock counts as half a cycle
  wire conv_edge = use_ext ? ext_edge : int_wrap;

  // internal conversion clock divider
  always_ff @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      int_cnt_reg <= 4'h0;
      int_clk_reg <= 1'b0;
    end else begin
      int_cnt_reg <= int_wrap ? 4'h0 : int_cnt_reg + 4'h1;
      int_clk_reg <= int_clk_reg ^ int_wrap;
    end
  end

  // ----------------------------------------------------------------
  // start decode and per-pair converters
  // ----------------------------------------------------------------
  logic [2:0] active;
  logic [2:0] active_next;
  logic [2:0] accept;
  logic [2:0] abort;
  logic [2:0] pd_reg;
  logic busy_reg;
  logic busy_out_reg;
  scsci_six_t results;
  wire seq_mode = use_ext & cw_reg[CW_SEQ];
  wire a_only = pins_reg.cfg_sw & ~seq_mode;
  wire [2:0] st_rise = pins_reg.start & ~pins_q_reg.start;
  // software mode outside sequential mode routes pair A start to all pairs
  wire [2:0] eff_rise = a_only ? {3{st_rise[0]}} : st_rise;
  wire [2:0] eff_level = a_only ? {3{pins_reg.start[0]}} : pins_reg.start;
  wire [2:0] pd_all = pd_reg | cw_reg[CW_PD_LSB +: 3];
  // any running pair blocks new starts outside sequential mode
  wire [2:0] free = seq_mode ? ~active : {3{~|active}};

  assign accept = eff_rise & free & ~pd_all;
  assign abort = active & ~eff_level;

  for (genvar p = 0; p < 3; p++) begin : g_pair
    scsci_conv_t st_reg;
    scsci_conv_t st_next;
    logic [5:0] cnt_reg;
    logic [31:0] held_reg;
    logic [31:0] res_reg;
    wire last = conv_edge && (cnt_reg == CONV_EDGE_LAST);

    // conversion sequence of one pair
    always_comb begin
      st_next = st_reg;
      case (st_reg)
        ST_IDLE: if (accept[p]) st_next = ST_WAIT;
        ST_WAIT: if (conv_edge) st_next = ST_CONV;
        ST_CONV: if (last) st_next = ST_IDLE;
        default: st_next = ST_IDLE;
      endcase
      if (abort[p]) begin
        st_next = ST_IDLE;
      end
    end

    // state, edge counter, held inputs and results
    always_ff @(posedge clk_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
        st_reg <= ST_IDLE;
        cnt_reg <= 6'h00;
        held_reg <= 32'h0000_0000;
        res_reg <= 32'h0000_0000;
      end else begin
        st_reg <= st_next;
        if (st_reg != ST_CONV) begin
          cnt_reg <= 6'h00;
        end else if (conv_edge) begin
          cnt_reg <= cnt_reg + 6'h01;
        end
        if (accept[p]) begin
          held_reg <= {sample_data_i[2*p], sample_data_i[2*p+1]};
        end
        if (st_reg == ST_CONV && last && !abort[p]) begin
          // two's complement, unused upper bits zero
          res_reg <= {held_reg[31:16] & RES_MASK,
            held_reg[15:0] & RES_MASK};
        end
      end
    end

    assign active[p] = (st_reg != ST_IDLE);
    assign active_next[p] = (st_next != ST_IDLE);
    assign results[2*p] = res_reg[31:16];
    assign results[2*p+1] = res_reg[15:0];
  end

  // busy and partial power-down flags
  always_ff @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      busy_reg <= 1'b0;
      busy_out_reg <= 1'b0;
      pd_reg <= 3'h0;
    end else begin
      busy_reg <= |active_next;
      busy_out_reg <= (|active_next) ^ cw_reg[CW_BUSY_POL];
      pd_reg <= pd_reg | abort;
    end
  end

  assign busy_int_o = busy_out_reg;
  assign pair_power_down_o = pd_reg;

  // ----------------------------------------------------------------
  // parallel port
  // ----------------------------------------------------------------
  logic [3:0] idx_reg;
  logic [15:0] lanes_reg;
  logic [15:0] word;
  logic [15:0] lanes_next;
  wire [2:0] ch = pins_reg.byte_mode ? idx_reg[3:1] : idx_reg[2:0];
  wire busy_fall = busy_reg & ~(|active_next);
  wire rd_end = ~pins_reg.cs_n & pins_reg.rd_n & ~pins_q_reg.rd_n;
  wire [3:0] idx_last = pins_reg.byte_mode ? PAR_LAST_BYTE : PAR_LAST_WORD;
  wire hi_byte = pins_reg.high_first ^ idx_reg[0];

  // word per read, or byte pairs on the upper lanes
  assign word = (ch > 3'h5) ? 16'h0000 : results[ch];
  assign lanes_next = pins_reg.byte_mode
    ? {(hi_byte ? word[15:8] : word[7:0]), 8'h00} : word;
  assign parallel_lanes_oe_o = ~pins_reg.if_serial & ~pins_reg.cs_n
    & ~pins_reg.rd_n;

  // read index steps at the end of each read strobe
  always_ff @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      idx_reg <= 4'h0;
      lanes_reg <= 16'h0000;
    end else begin
      if (busy_fall || pins_reg.cs_n) begin
        idx_reg <= 4'h0;
      end else if (rd_end) begin
        idx_reg <= (idx_reg == idx_last) ? 4'h0 : idx_reg + 4'h1;
      end
      lanes_reg <= lanes_next;
    end
  end

  assign parallel_lanes_o = lanes_reg;

  // ----------------------------------------------------------------
  // serial port: snapshot handed over while frame sync is high
  // ----------------------------------------------------------------
  scsci_six_t snap_reg;

  // snapshot frozen for the whole frame
  always_ff @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      snap_reg <= '0;
    end else if (pins_reg.fs) begin
      snap_reg <= results;
    end
  end

  // ----------------------------------------------------------------
  // link domain
  // ----------------------------------------------------------------
  logic [3:0] lsel_meta_reg;
  logic [3:0] lsel_sync_reg;
  logic [3:0] lsel_reg;
  logic in_frame_reg;
  logic [FRAME_BITS-1:0] sh_a_reg;
  logic [FRAME_BITS-1:0] sh_b_reg;
  logic [FRAME_BITS-1:0] sh_c_reg;
  logic [FRAME_BITS-1:0] ld_a;
  logic [FRAME_BITS-1:0] ld_b;
  logic [FRAME_BITS-1:0] ld_c;
  logic [5:0] cfg_cnt_reg;
  logic [31:0] cfg_sh_reg;
  logic cfg_full_reg;
  wire frame_clr = frame_sync_i | ~rst_n_reg;
  wire three = lsel_reg[0];
  wire two = ~lsel_reg[0] & lsel_reg[1];

  // output enables and interface select: two flops, held during a frame
  // so the link clock may stay parked between frames
  always_ff @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      lsel_meta_reg <= 4'h0;
      lsel_sync_reg <= 4'h0;
      lsel_reg <= 4'h0;
    end else begin
      lsel_meta_reg <= {interface_select_i, serial_output_enable_i.sel_a,
        serial_output_enable_i.sel_b, serial_output_enable_i.sel_c};
      lsel_sync_reg <= lsel_meta_reg;
      if (pins_reg.fs) begin
        lsel_reg <= lsel_sync_reg;
      end
    end
  end

  // frame contents per enabled output count
  assign ld_a = three ? {snap_reg[0], snap_reg[1], 64'h0}
    : two ? {snap_reg[0], snap_reg[1], snap_reg[4], 48'h0}
    : {snap_reg[0], snap_reg[1], snap_reg[2], snap_reg[3], snap_reg[4],
      snap_reg[5]};
  assign ld_b = three ? {snap_reg[2], snap_reg[3], 64'h0}
    : two ? {snap_reg[2], snap_reg[3], snap_reg[5], 48'h0}
    : '0;
  assign ld_c = three ? {snap_reg[4], snap_reg[5], 64'h0} : '0;

  // first rising edge in the frame loads, later edges shift msb first
  always_ff @(posedge sclk_i or posedge frame_clr) begin
    if (frame_clr) begin
      in_frame_reg <= 1'b0;
      sh_a_reg <= '0;
      sh_b_reg <= '0;
      sh_c_reg <= '0;
    end else if (!in_frame_reg) begin
      in_frame_reg <= 1'b1;
      sh_a_reg <= ld_a;
      sh_b_reg <= ld_b;
      sh_c_reg <= ld_c;
    end else begin
      sh_a_reg <= {sh_a_reg[FRAME_BITS-2:0], 1'b0};
      sh_b_reg <= {sh_b_reg[FRAME_BITS-2:0], 1'b0};
      sh_c_reg <= {sh_c_reg[FRAME_BITS-2:0], 1'b0};
    end
  end

  assign serial_output_a_o = lsel_reg[3] & sh_a_reg[FRAME_BITS-1];
  assign serial_output_b_o = lsel_reg[3] & sh_b_reg[FRAME_BITS-1];
  assign serial_output_c_o = lsel_reg[3] & sh_c_reg[FRAME_BITS-1];

  // config bit counter, cleared between frames
  always_ff @(negedge sclk_i or posedge frame_clr) begin
    if (frame_clr) begin
      cfg_cnt_reg <= 6'h00;
    end else if (cfg_cnt_reg <= CFG_LAST_BIT) begin
      cfg_cnt_reg <= cfg_cnt_reg + 6'h01;
    end
  end

  // config word shifted in on falling edges
  always_ff @(negedge sclk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      cfg_sh_reg <= 32'h0000_0000;
      cfg_full_reg <= 1'b0;
    end else if (cfg_cnt_reg <= CFG_LAST_BIT) begin
      cfg_sh_reg <= {cfg_sh_reg[30:0], serial_config_input_i};
      cfg_full_reg <= (cfg_cnt_reg == CFG_LAST_BIT);
    end
  end

  assign ser_rx_word = cfg_sh_reg;
  assign ser_rx_full = cfg_full_reg;

endmodule

// >>> verification/scsci_props.sv
`timescale 1ns/100ps
// ----------------------------------------------------------
// port checker of the conversion interface
// ----------------------------------------------------------
module scsci_props (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [2:0] pair_conversion_start_i,
  input wire logic pin_or_register_config_select_i,
  input wire logic interface_select_i,
  input wire logic cs_n_i,
  input wire logic [31:0] control_word_i,
  input wire logic busy_int_o,
  input wire logic ref_range_o,
  input wire logic [9:0] ref_dac_code_o,
  input wire logic [2:0] pair_power_down_o,
  input wire logic parallel_lanes_oe_o
);
  logic [3:0] run_cnt;
  logic [7:0] busy_len;
  wire logic busy_act;
  wire logic cw_used;
  wire logic run_ok;
  wire logic [33:0] cfg_all;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // busy in its active sense, word taken from port, settled time
  assign busy_act = busy_int_o ^ control_word_i[20];
  assign cw_used = !(pin_or_register_config_select_i && interface_select_i);
  assign run_ok = run_cnt == 4'hf;
  assign cfg_all = {pin_or_register_config_select_i, interface_select_i,
    control_word_i};

  // cycles since reset and length of the busy phase
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_cnt <= 4'h0;
      busy_len <= 8'h00;
    end else begin
      run_cnt <= run_ok ? run_cnt : run_cnt + 4'h1;
      busy_len <= busy_act ? busy_len + 8'h01 : 8'h00;
    end
  end

  a_ref_code: assert property (
    (run_ok && cw_used && $stable(cfg_all))[*6]
    |-> ref_dac_code_o == control_word_i[9:0]) else $error("ref code");
  a_ref_range: assert property (
    (run_ok && cw_used && $stable(cfg_all))[*6]
    |-> ref_range_o == control_word_i[18]) else $error("ref range");
  a_busy_idle: assert property (
    (run_ok && cw_used && $stable(cfg_all) && !(|pair_conversion_start_i))[*8]
    |-> busy_int_o == control_word_i[20]) else $error("busy level");
  a_busy_rise: assert property (
    run_ok && cw_used && $rose(pair_conversion_start_i[0]) && !busy_act
    && pair_power_down_o == 3'h0 && control_word_i[15:13] == 3'h0
    |-> ##[2:6] busy_act) else $error("busy not raised");
  a_conv_len: assert property (
    $fell(busy_act) && $past(pair_conversion_start_i[0]) && cw_used
    && !control_word_i[11] |-> $past(busy_len) inside {[108:118]})
    else $error("conversion length");
  a_pd_abort: assert property (
    busy_act && cw_used && $fell(pair_conversion_start_i[0])
    |-> ##[1:8] pair_power_down_o[0]) else $error("no power down");
  a_pd_sticky: assert property (
    |pair_power_down_o |=> (pair_power_down_o & $past(pair_power_down_o))
    == $past(pair_power_down_o)) else $error("power down lost");
  a_oe_off: assert property (
    (interface_select_i || cs_n_i)[*3] |-> !parallel_lanes_oe_o)
    else $error("lanes driven");
endmodule

bind scsci_top scsci_props scsci_props_inst (
  .clk_i(clk_i), .rst_n_i(rst_n_i),
  .pair_conversion_start_i(pair_conversion_start_i),
  .pin_or_register_config_select_i(pin_or_register_config_select_i),
  .interface_select_i(interface_select_i), .cs_n_i(cs_n_i),
  .control_word_i(control_word_i), .busy_int_o(busy_int_o),
  .ref_range_o(ref_range_o), .ref_dac_code_o(ref_dac_code_o),
  .pair_power_down_o(pair_power_down_o),
  .parallel_lanes_oe_o(parallel_lanes_oe_o)
);

// >>> verification/scsci_host.sv
`timescale 1ns/100ps
// ----------------------------------------------------------
// serial host: frames, control word, capture
// ----------------------------------------------------------
module scsci_host (
  input wire logic serial_output_a_i,
  input wire logic serial_output_b_i,
  input wire logic serial_output_c_i,
  output logic sclk_o,
  output logic frame_sync_o,
  output logic serial_config_input_o
);
  logic [95:0] cap_a;
  logic [95:0] cap_b;
  logic [95:0] cap_c;

  // link clock parked low outside frames
  initial begin
    sclk_o = 1'b0;
    frame_sync_o = 1'b1;
    serial_config_input_o = 1'b0;
  end

  // one 96 bit frame, control word in front, sample on falling
  task automatic frame(input logic [31:0] cfg);
    int i;
    #3;
    frame_sync_o = 1'b0;
    #40;
    for (i = 0; i < 96; i++) begin
      serial_config_input_o = (i < 32) ? cfg[31 - i] : 1'b0;
      sclk_o = 1'b1;
      #40;
      sclk_o = 1'b0;
      cap_a = {cap_a[94:0], serial_output_a_i};
      cap_b = {cap_b[94:0], serial_output_b_i};
      cap_c = {cap_c[94:0], serial_output_c_i};
      #40;
    end
    frame_sync_o = 1'b1;
    serial_config_input_o = ~serial_config_input_o;
  endtask
endmodule

// >>> verification/scsci_top_tb.sv
`timescale 1ns/100ps
module scsci_top_tb;
  import scsci_pkg::*;
  // ----------------------------------------------------------
  // bench signals and instances
  // ----------------------------------------------------------
  logic clk, rst_n, external_conversion_clock, xen, hwsw, ifs, wsel, hb, cs_n, rd_n;
  logic sclk, fs, serial_config_input, busy, rr, oe, so_a, so_b, so_c;
  logic [2:0] start, pd;
  logic [9:0] dac;
  logic [15:0] lanes;
  logic [31:0] cw;
  scsci_sel_t sel;
  scsci_six_t sd, res, want;
  int n_fail, checks_done, len;

  scsci_top scsci_top_inst (
    .clk_i(clk), .rst_n_i(rst_n), .sclk_i(sclk),
    .external_conversion_clock_i(external_conversion_clock), .pair_conversion_start_i(start),
    .pin_or_register_config_select_i(hwsw), .interface_select_i(ifs),
    .width_select_i(wsel), .byte_order_select_i(hb), .cs_n_i(cs_n),
    .rd_n_i(rd_n), .frame_sync_i(fs), .serial_config_input_i(serial_config_input),
    .serial_output_enable_i(sel), .control_word_i(cw),
    .sample_data_i(sd), .busy_int_o(busy), .ref_range_o(rr),
    .ref_dac_code_o(dac), .pair_power_down_o(pd),
    .parallel_lanes_o(lanes), .parallel_lanes_oe_o(oe),
    .serial_output_a_o(so_a), .serial_output_b_o(so_b),
    .serial_output_c_o(so_c)
  );
  scsci_host scsci_host_inst (
    .serial_output_a_i(so_a), .serial_output_b_i(so_b),
    .serial_output_c_i(so_c), .sclk_o(sclk), .frame_sync_o(fs),
    .serial_config_input_o(serial_config_input)
  );

  // system clock, conversion clock gated by xen
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always #32 external_conversion_clock = xen ? ~external_conversion_clock : 1'b0;

  // compare and count
  task automatic chk(input string what, input logic [95:0] seen,
    input logic [95:0] exp_v);
    checks_done++;
    if (seen !== exp_v) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp_v, seen);
    end
  endtask

  // verdict and end of run
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // reset held 12 cycles, outputs cleared meanwhile
  task automatic reset_dut;
    @(negedge clk);
    rst_n = 1'b0;
    repeat (12) @(negedge clk);
    chk("reset outputs", {pd, dac, busy, rr}, 0);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
  endtask

  // one conversion; late starts rise mid-conversion
  task automatic conv(input logic [2:0] st, input logic [2:0] late);
    int n;
    want = sd;
    @(negedge clk);
    start = st;
    for (n = 0; n < 20 && busy === cw[20]; n++) @(negedge clk);
    sd = ~sd;
    repeat (20) @(negedge clk);
    start = st | late;
    for (len = 20; len < 400 && busy !== cw[20]; len++) @(negedge clk);
    repeat (4) @(negedge clk);
    chk("busy after end", busy, cw[20]);
    start = 3'h0;
    repeat (8) @(negedge clk);
  endtask

  // one parallel read strobe
  task automatic rd_word(output logic [15:0] d);
    @(negedge clk);
    rd_n = 1'b0;
    repeat (4) @(negedge clk);
    chk("lanes enable", oe, 1'b1);
    d = lanes;
    rd_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask

  // all results through the parallel port, words or bytes
  task automatic rd_all;
    logic [15:0] d;
    logic [15:0] w;
    int k;
    cs_n = 1'b0;
    for (k = 0; k < (wsel ? 12 : 6); k++) begin
      rd_word(d);
      w = (wsel ? res[k / 2] : res[k]) & RES_MASK;
      if (wsel) w = {((k % 2 == 0) == hb) ? w[15:8] : w[7:0], 8'h00};
      chk("lanes", d, w);
    end
    @(negedge clk);
    cs_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask

  // one serial frame with the given output selection
  task automatic ser(input scsci_sel_t s, input logic [31:0] cfg);
    logic [95:0] ea;
    logic [95:0] eb;
    @(negedge clk);
    sel = s;
    repeat (6) @(negedge clk);
    ea = {res[0], res[1], res[2], res[3], res[4], res[5]};
    eb = {res[2], res[3], res[5], 48'h0};
    if (s.sel_b) ea = {res[0], res[1], res[4], 48'h0};
    if (s.sel_c) ea = {res[0], res[1], 64'h0};
    if (s.sel_c) eb = {res[2], res[3], 64'h0};
    scsci_host_inst.frame(cfg);
    @(negedge clk);
    chk("serial a", scsci_host_inst.cap_a, ea);
    if (s.sel_b) chk("serial b", scsci_host_inst.cap_b, eb);
    if (s.sel_c) chk("serial c", scsci_host_inst.cap_c, {res[4], res[5],
      64'h0});
  endtask

  // main sequence
  initial begin
    {n_fail, checks_done} = '0;
    {rst_n, external_conversion_clock, xen, hwsw, ifs, wsel, hb, start} = '0;
    {cs_n, rd_n} = 2'b11;
    sel = 3'b111;
    cw = 32'h0014_00cc;
    sd = {16'h8000, 16'h7fff, 16'h1234, 16'hfedc, 16'h0001, 16'hffff};
    res = '0;
    reset_dut;
    repeat (8) @(negedge clk);
    chk("ref code", {rr, dac, busy}, {1'b1, 10'h0cc, 1'b1});
    cw = 32'h0000_03ff;
    repeat (8) @(negedge clk);
    chk("ref code", {rr, dac, busy}, {1'b0, 10'h3ff, 1'b0});
    conv(3'h7, 3'h0);
    chk("length", (len - CONV_CYCLES_X2 * INT_HALF_CYC) inside {[-2:12]},
      1'b1);
    res = want;
    rd_all;
    wsel = 1'b1;
    rd_all;
    hb = 1'b1;
    rd_all;
    wsel = 1'b0;
    conv(3'h1, 3'h2);
    res[1:0] = want[1:0];
    rd_all;
    hwsw = 1'b1;
    conv(3'h1, 3'h0);
    res = want;
    rd_all;
    cw = 32'h0000_0bff;
    xen = 1'b1;
    conv(3'h1, 3'h0);
    chk("length", (len - CONV_CYCLES_X2 * 4) inside {[-2:12]}, 1'b1);
    res = want;
    {xen, hwsw, ifs} = 3'b001;
    ser(3'b111, 32'h0);
    ser(3'b110, 32'h0);
    ser(3'b100, 32'h0);
    hwsw = 1'b1;
    ser(3'b100, 32'h0001_01ff);
    repeat (8) @(negedge clk);
    chk("serial config", dac, 10'h1ff);
    {hwsw, ifs} = 2'b00;
    cw = 32'h0000_03ff;
    reset_dut;
    start = 3'h1;
    repeat (30) @(negedge clk);
    start = 3'h0;
    repeat (12) @(negedge clk);
    chk("power down", pd, 3'h1);
    start = 3'h1;
    repeat (12) @(negedge clk);
    chk("busy refused", busy, 1'b0);
    start = 3'h0;
    reset_dut;
    stop_test;
  end

  // watchdog against a hang
  initial begin
    #400_000;
    n_fail++;
    stop_test;
  end
endmodule
